// File: verilog/pmuisa_map.svh
`ifndef PMUISA_MAP_SVH
`define PMUISA_MAP_SVH

`define PMUISA_GRP_W        8
`define PMUISA_NSRC         32
`define PMUISA_PIN_W        13
`define PMUISA_GPIO_W       8

// group one bits
`define PMUISA_B1_SUPPLY    6
`define PMUISA_B1_HOT       5
`define PMUISA_B1_PDOWN     4
`define PMUISA_B1_RWAKE     3
`define PMUISA_B1_HOLD      2
`define PMUISA_B1_BUTTON    1
// group two bits
`define PMUISA_B2_FAULT     6
`define PMUISA_B2_RSTIN     4
`define PMUISA_B2_WDOG      2
`define PMUISA_B2_TICK      1
`define PMUISA_B2_ALARM     0
// group three bits
`define PMUISA_B3_VBUS      7
`define PMUISA_B3_ADC_DONE  2
`define PMUISA_B3_ADC_CMP1  1
`define PMUISA_B3_ADC_CMP0  0

// synchronised pin vector positions
`define PMUISA_P_PDOWN      0
`define PMUISA_P_RWAKE      1
`define PMUISA_P_BUTTON     2
`define PMUISA_P_RSTIN      3
`define PMUISA_P_VBUS       4
`define PMUISA_P_GPIO       5

// sources that may raise a wake request when unmasked (flat index)
`define PMUISA_WAKE_CAP     32'hFF87_4300
`define PMUISA_RD_UNMAPPED  8'hFF
`define PMUISA_INT_RST      1'b1
`define PMUISA_MCLK_HZ      50_000_000
`define PMUISA_HOLD_UNIT_MS 1000
`endif

// File: verilog/pmuisa_pkg.sv
package pmuisa_pkg;
  typedef enum logic [1:0] {
    PMUISA_OFF,
    PMUISA_ACTIVE,
    PMUISA_SLEEP
  } pmuisa_pwr_t;

  typedef enum logic {
    PMUISA_PORT_CFG,
    PMUISA_PORT_VSCALE
  } pmuisa_port_t;

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
  } pmuisa_sync_st_t;

  typedef struct packed {
    logic status;
    logic pending;
  } pmuisa_cell_st_t;

  typedef struct packed {
    logic [12:0] pin_prev;
    logic [5:0]  ev_prev;
    logic [31:0] hold_cnt;
    logic        hold_done;
    logic [2:0]  last_grp;
    logic        last_vld;
    logic [7:0]  rdata;
    logic        ack;
    logic        err;
    logic        int_out;
    logic        wake;
  } pmuisa_top_st_t;
endpackage : pmuisa_pkg

// File: verilog/pmuisa_sync.sv
`timescale 1ns/1ps
module pmuisa_sync
  import pmuisa_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [12:0] i_async,
  output logic      [12:0] o_sync
);
  pmuisa_sync_st_t st_q;
  pmuisa_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = i_async;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sync = st_q.s2;
endmodule : pmuisa_sync

// File: verilog/pmuisa_cell.sv
`timescale 1ns/1ps
module pmuisa_cell
  import pmuisa_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_event,
  input  wire logic i_clear,
  input  wire logic i_take_pending,
  input  wire logic i_line_active,
  input  wire logic i_pending_en,
  output logic      o_status,
  output logic      o_pending
);
  pmuisa_cell_st_t st_q;
  pmuisa_cell_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (i_clear) begin
      if (!st_q.pending) begin
        st_d.status = 1'b0;
      end else if (i_take_pending) begin
        // pending event becomes the live one; status stays set
        st_d.pending = 1'b0;
      end
    end
    // set wins over a clear in the same cycle
    if (i_event) begin
      if (!st_d.status) begin
        st_d.status = 1'b1;
      end else if (i_line_active && i_pending_en) begin
        st_d.pending = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_status  = st_q.status;
  assign o_pending = st_q.pending;
endmodule : pmuisa_cell

// File: verilog/pmuisa_top.sv
`timescale 1ns/1ps
`include "pmuisa_map.svh"
module pmuisa_top
  import pmuisa_pkg::*;
#(
  parameter int unsigned HOLD_UNIT_CYC =
    `PMUISA_HOLD_UNIT_MS * (`PMUISA_MCLK_HZ / 1000)
)
(
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // pins from outside the clock domain
  input  wire logic         i_power_down_pin,
  input  wire logic         i_remote_wake_pin,
  input  wire logic         i_power_button_pin,
  input  wire logic         i_reset_in_pin,
  input  wire logic         i_vbus_pin,
  input  wire logic [7:0]   i_gpio_pin,
  // internal monitors, same clock
  input  wire logic         i_supply_voltage_monitor,
  input  wire logic         i_die_overtemperature,
  input  wire logic         i_regulator_fault,
  input  wire logic         i_watchdog_expiry,
  input  wire logic         i_rtc_tick,
  input  wire logic         i_rtc_alarm,
  input  wire logic         i_adc_manual_conversion_done,
  input  wire logic         i_adc_periodic_compare_one,
  input  wire logic         i_adc_periodic_compare_zero,
  input  pmuisa_pwr_t       i_power_state,
  // configuration
  input  wire logic         i_iface_spi,
  input  wire logic         i_rtc_tick_en,
  input  wire logic [1:0]   i_hold_delay_setting,
  input  wire logic [7:0]   i_gpio_rise_en,
  input  wire logic [7:0]   i_gpio_fall_en,
  input  wire logic [7:0]   i_mask_group_one,
  input  wire logic [7:0]   i_mask_group_two,
  input  wire logic [7:0]   i_mask_group_three,
  input  wire logic [7:0]   i_mask_group_four,
  input  wire logic         i_clear_on_write,
  input  wire logic         i_pending_en,
  input  wire logic         i_int_active_high,
  input  wire logic         i_int_mask_in_sleep,
  // host register access
  input  wire logic         i_acc_valid,
  input  pmuisa_port_t      i_acc_port,
  input  wire logic         i_acc_write,
  input  wire logic [2:0]   i_acc_group,
  input  wire logic [7:0]   i_acc_wdata,
  output logic              o_acc_ack,
  output logic              o_acc_err,
  output logic [7:0]        o_acc_rdata,
  // combined outputs
  output logic              o_int,
  output logic              o_wake_req
);

  function automatic int unsigned flat(input int unsigned grp,
                                       input int unsigned bitn);
    flat = grp * `PMUISA_GRP_W + bitn;
  endfunction : flat

  // status groups live only behind the configuration port; in the SPI
  // build the vscale port is still refused, only the configuration port answers
  function automatic logic reach_ok(input pmuisa_port_t port,
                                    input logic         spi);
    reach_ok = (port == PMUISA_PORT_CFG);
    if (spi && port != PMUISA_PORT_CFG) begin
      reach_ok = 1'b0;
    end
  endfunction : reach_ok

  // groups 0-3 return status, 4-6 live line levels, 7 the general pins
  function automatic logic [7:0] read_group(input logic [2:0]  grp,
                                            input logic [31:0] stat,
                                            input logic [7:0]  lv1,
                                            input logic [7:0]  lv2,
                                            input logic [7:0]  lv3,
                                            input logic [7:0]  lvp);
    read_group = 8'h00;
    unique case (grp)
      3'h0: read_group = stat[7:0];
      3'h1: read_group = stat[15:8];
      3'h2: read_group = stat[23:16];
      3'h3: read_group = stat[31:24];
      3'h4: read_group = lv1;
      3'h5: read_group = lv2;
      3'h6: read_group = lv3;
      3'h7: read_group = lvp;
    endcase
  endfunction : read_group

  // bits of one group that an accepted access clears
  function automatic logic [7:0] clear_bits(input logic       wr,
                                            input logic       cow,
                                            input logic [7:0] wdata);
    clear_bits = 8'h00;
    if (wr && cow) begin
      clear_bits = wdata;
    end else if (!wr && !cow) begin
      clear_bits = 8'hFF;
    end
  endfunction : clear_bits

  pmuisa_top_st_t st_q;
  pmuisa_top_st_t st_d;

  logic [12:0] pin_raw;
  logic [12:0] pin_s;
  logic [31:0] ev;
  logic [31:0] mask_flat;
  logic [31:0] status;
  logic [31:0] pending;
  logic [31:0] clr;
  logic [3:0]  take;
  logic [5:0]  ev_now;
  logic [5:0]  ev_rise;
  logic [5:0]  ev_fall;
  logic [12:0] pin_rise;
  logic [12:0] pin_fall;
  logic        line_active;
  logic        on_state;
  logic        acc_ok;
  logic [31:0] hold_limit;
  logic [7:0]  line_g1;
  logic [7:0]  line_g2;
  logic [7:0]  line_g3;
  logic        wake_now;

  assign pin_raw = {i_gpio_pin, i_vbus_pin, i_reset_in_pin,
                    i_power_button_pin, i_remote_wake_pin,
                    i_power_down_pin};

  pmuisa_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async (pin_raw),
    .o_sync  (pin_s)
  );

  assign mask_flat = {i_mask_group_four, i_mask_group_three,
                      i_mask_group_two, i_mask_group_one};
  assign on_state  = (i_power_state == PMUISA_ACTIVE) ||
                     (i_power_state == PMUISA_SLEEP);

  // edge detection on same-clock monitors
  assign ev_now  = {i_rtc_alarm, i_rtc_tick, i_watchdog_expiry,
                    i_regulator_fault, i_die_overtemperature,
                    i_supply_voltage_monitor};
  genvar ei;
  generate
    for (ei = 0; ei < 6; ei++) begin : g_mon_edge
      assign ev_rise[ei] = ev_now[ei] & ~st_q.ev_prev[ei];
      assign ev_fall[ei] = ~ev_now[ei] & st_q.ev_prev[ei];
    end
  endgenerate

  // pins are edge-detected only after the two-flop synchroniser
  genvar pi;
  generate
    for (pi = 0; pi < `PMUISA_PIN_W; pi++) begin : g_pin_edge
      assign pin_rise[pi] = pin_s[pi] & ~st_q.pin_prev[pi];
      assign pin_fall[pi] = ~pin_s[pi] & st_q.pin_prev[pi];
    end
  endgenerate

  assign hold_limit = HOLD_UNIT_CYC * ({30'd0, i_hold_delay_setting} + 32'd1);

  // raw events before masking, in flat status order
  always_comb begin
    ev = '0;
    ev[flat(0, `PMUISA_B1_SUPPLY)] = ev_rise[0] | ev_fall[0];
    ev[flat(0, `PMUISA_B1_HOT)]    = (ev_rise[1] | ev_fall[1])
                                     & on_state;
    ev[flat(0, `PMUISA_B1_PDOWN)]  = pin_rise[`PMUISA_P_PDOWN]
                                     | pin_fall[`PMUISA_P_PDOWN];
    ev[flat(0, `PMUISA_B1_RWAKE)]  = pin_fall[`PMUISA_P_RWAKE]
                                     & on_state;
    ev[flat(0, `PMUISA_B1_HOLD)]   = !st_q.hold_done
                                     && !pin_s[`PMUISA_P_BUTTON]
                                     && st_q.hold_cnt >= hold_limit;
    ev[flat(0, `PMUISA_B1_BUTTON)] = pin_fall[`PMUISA_P_BUTTON]
                                     & on_state;
    ev[flat(1, `PMUISA_B2_FAULT)]  = ev_rise[2];
    ev[flat(1, `PMUISA_B2_RSTIN)]  = pin_rise[`PMUISA_P_RSTIN];
    ev[flat(1, `PMUISA_B2_WDOG)]   = ev_rise[3];
    ev[flat(1, `PMUISA_B2_TICK)]   = ev_rise[4] & i_rtc_tick_en;
    ev[flat(1, `PMUISA_B2_ALARM)]  = ev_rise[5];
    ev[flat(2, `PMUISA_B3_VBUS)]   = pin_rise[`PMUISA_P_VBUS]
                                     | pin_fall[`PMUISA_P_VBUS];
    // level sources: no edge detector, set while asserted
    ev[flat(2, `PMUISA_B3_ADC_DONE)] = i_adc_manual_conversion_done;
    ev[flat(2, `PMUISA_B3_ADC_CMP1)] = i_adc_periodic_compare_one;
    ev[flat(2, `PMUISA_B3_ADC_CMP0)] = i_adc_periodic_compare_zero;
    ev[31:24] = (pin_rise[12:5] & i_gpio_rise_en)
              | (pin_fall[12:5] & i_gpio_fall_en);
  end

  // clear strobes and the two-register pending handshake
  always_comb begin
    clr    = '0;
    take   = '0;
    acc_ok = i_acc_valid && reach_ok(i_acc_port, i_iface_spi);
    for (int g = 0; g < 4; g++) begin
      take[g] = !(st_q.last_vld && st_q.last_grp == 3'(g));
      if (acc_ok && i_acc_group == 3'(g)) begin
        clr[g*8 +: 8] = clear_bits(i_acc_write, i_clear_on_write,
                                   i_acc_wdata);
      end
    end
  end

  // a masked bit can still hold status but never drives the line
  assign line_active = |(status & ~mask_flat);

  genvar gi;
  generate
    for (gi = 0; gi < `PMUISA_NSRC; gi++) begin : g_cell
      pmuisa_cell u_cell (
        .i_mclk         (i_mclk),
        .i_rst_n        (i_rst_n),
        .i_event        (ev[gi] & ~mask_flat[gi]),
        .i_clear        (clr[gi]),
        .i_take_pending (take[gi / 8]),
        .i_line_active  (line_active),
        .i_pending_en   (i_pending_en),
        .o_status       (status[gi]),
        .o_pending      (pending[gi])
      );
    end
  endgenerate

  // real-time line states
  assign line_g1 = {1'b0, i_supply_voltage_monitor, i_die_overtemperature,
                    pin_s[`PMUISA_P_PDOWN], pin_s[`PMUISA_P_RWAKE],
                    st_q.hold_done, pin_s[`PMUISA_P_BUTTON], 1'b0};
  assign line_g2 = {1'b0, i_regulator_fault, 1'b0, pin_s[`PMUISA_P_RSTIN],
                    1'b0, i_watchdog_expiry, i_rtc_tick, i_rtc_alarm};
  assign line_g3 = {pin_s[`PMUISA_P_VBUS], 4'h0,
                    i_adc_manual_conversion_done,
                    i_adc_periodic_compare_one,
                    i_adc_periodic_compare_zero};

  // button and remote wake always request power-on, mask ignored
  assign wake_now = pin_fall[`PMUISA_P_BUTTON]
                  | pin_fall[`PMUISA_P_RWAKE]
                  | |(ev & ~mask_flat & `PMUISA_WAKE_CAP);

  always_comb begin
    st_d          = st_q;
    st_d.pin_prev = pin_s;
    st_d.ev_prev  = ev_now;
    st_d.ack      = 1'b0;
    st_d.err      = 1'b0;
    st_d.wake     = wake_now;
    // long-hold timer: one event per press, rearmed on release
    if (pin_s[`PMUISA_P_BUTTON]) begin
      st_d.hold_cnt  = '0;
      st_d.hold_done = 1'b0;
    end else begin
      if (st_q.hold_cnt < hold_limit) begin
        st_d.hold_cnt = st_q.hold_cnt + 32'd1;
      end
      if (ev[flat(0, `PMUISA_B1_HOLD)]) begin
        st_d.hold_done = 1'b1;
      end
    end
    if (i_acc_valid) begin
      st_d.ack   = 1'b1;
      st_d.rdata = `PMUISA_RD_UNMAPPED;
      if (!acc_ok) begin
        st_d.err = 1'b1;
      end else begin
        st_d.last_grp = i_acc_group;
        st_d.last_vld = 1'b1;
        st_d.rdata    = read_group(i_acc_group, status, line_g1, line_g2,
                                   line_g3, pin_s[12:5]);
      end
    end
    // sleep masking holds the line idle but keeps status
    if (line_active &&
        !(i_int_mask_in_sleep && i_power_state == PMUISA_SLEEP)) begin
      st_d.int_out = i_int_active_high;
    end else begin
      st_d.int_out = !i_int_active_high;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q         <= '0;
      st_q.int_out <= `PMUISA_INT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_acc_ack   = st_q.ack;
  assign o_acc_err   = st_q.err;
  assign o_acc_rdata = st_q.rdata;
  assign o_int       = st_q.int_out;
  assign o_wake_req  = st_q.wake;
endmodule : pmuisa_top

// File: verification/pmuisa_monitor.sv
`timescale 1ns/1ps
module pmuisa_monitor
  import pmuisa_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_acc_valid,
  input  pmuisa_port_t    i_acc_port,
  input  wire logic       o_acc_ack,
  input  wire logic       o_acc_err,
  input  wire logic [7:0] o_acc_rdata,
  input  wire logic       o_int,
  input  wire logic       o_wake_req,
  input  wire logic       i_int_active_high,
  input  wire logic       i_int_mask_in_sleep,
  input  wire logic [7:0] i_mask_group_one,
  input  wire logic [7:0] i_mask_group_two,
  input  wire logic [7:0] i_mask_group_three,
  input  wire logic [7:0] i_mask_group_four,
  input  wire logic       i_watchdog_expiry,
  input  wire logic       i_remote_wake_pin
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_ack_follows: assert property (i_acc_valid |=> o_acc_ack)
    else $error("access not acknowledged");
  a_no_stray_ack: assert property (!i_acc_valid |=> !o_acc_ack)
    else $error("ack without access");
  a_vscale_refused: assert property (
    i_acc_valid && i_acc_port == PMUISA_PORT_VSCALE
    |=> o_acc_err && o_acc_rdata == 8'hFF) else $error("vscale not refused");
  a_cfg_accepted: assert property (
    i_acc_valid && i_acc_port == PMUISA_PORT_CFG |=> !o_acc_err)
    else $error("config access refused");
  a_rdata_holds: assert property (
    !i_acc_valid |=> $stable(o_acc_rdata)) else $error("rdata moved");
  a_idle_masked: assert property (
    (&{i_mask_group_one, i_mask_group_two, i_mask_group_three,
       i_mask_group_four} && $stable(i_int_active_high)) [*2]
    |-> o_int == !i_int_active_high) else $error("masked line active");
  a_wdog_raises: assert property (
    $rose(i_watchdog_expiry) && !i_mask_group_two[2] && !i_int_mask_in_sleep
    |-> ##[1:3] o_int == i_int_active_high) else $error("watchdog lost");
  a_rwake_wakes: assert property (
    $fell(i_remote_wake_pin) |-> ##[2:5] o_wake_req)
    else $error("remote wake missing");
endmodule : pmuisa_monitor

bind pmuisa_top pmuisa_monitor u_mon (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_acc_valid(i_acc_valid),
  .i_acc_port(i_acc_port), .o_acc_ack(o_acc_ack), .o_acc_err(o_acc_err),
  .o_acc_rdata(o_acc_rdata), .o_int(o_int), .o_wake_req(o_wake_req),
  .i_int_active_high(i_int_active_high),
  .i_int_mask_in_sleep(i_int_mask_in_sleep),
  .i_mask_group_one(i_mask_group_one), .i_mask_group_two(i_mask_group_two),
  .i_mask_group_three(i_mask_group_three),
  .i_mask_group_four(i_mask_group_four),
  .i_watchdog_expiry(i_watchdog_expiry),
  .i_remote_wake_pin(i_remote_wake_pin)
);

// File: verification/pmuisa_host_model.sv
`timescale 1ns/1ps
module pmuisa_host_model
  import pmuisa_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_ack,
  input  wire logic       i_err,
  input  wire logic [7:0] i_rdata,
  output logic            o_valid,
  output pmuisa_port_t    o_port,
  output logic            o_write,
  output logic [2:0]      o_group,
  output logic [7:0]      o_wdata
);
  initial begin
    o_valid = 1'b0;
    o_port = PMUISA_PORT_CFG;
    o_write = 1'b0;
    o_group = 3'h0;
    o_wdata = 8'h00;
  end
  // valid is a one-cycle pulse; the answer is taken the cycle after
  task automatic acc(input pmuisa_port_t p, input logic w,
                     input logic [2:0] g, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    @(posedge i_mclk);
    o_valid <= 1'b1;
    o_port <= p;
    o_write <= w;
    o_group <= g;
    o_wdata <= d;
    @(posedge i_mclk);
    o_valid <= 1'b0;
    // released data must not look valid
    o_wdata <= ~d;
    // the answer stands in the cycle after the request edge
    @(posedge i_mclk);
    r = (i_ack === 1'b1) ? i_rdata : 8'hXX;
    e = i_err;
  endtask : acc
endmodule : pmuisa_host_model

// File: verification/tb_pmu_interrupt_source_aggregator.sv
`timescale 1ns/1ps
module tb_pmu_interrupt_source_aggregator
  import pmuisa_pkg::*;
();
  logic            clk = 1'b0, rst_n = 1'b0;
  logic            pdn = 1'b0, rwk = 1'b1, btn = 1'b1, vbus = 1'b0;
  logic            spi = 1'b0, ten = 1'b1, cow = 1'b0, pen = 1'b0;
  logic            ah = 1'b0, ack, err, irq, wake, e;
  logic            ms = 1'b0, hv, hw;
  logic [1:0]      hld = 2'h0;
  logic [2:0]      hg;
  logic [7:0]      hwd;
  pmuisa_port_t    hp;
  logic [1:0]      s1 = 2'h0;
  logic [4:0]      s2 = 5'h00;
  logic [2:0]      adc = 3'h0;
  logic [7:0]      gpio = 8'h00, re = 8'h00, fe = 8'h00;
  logic [7:0]      rdat, r, w0, n_wake = 8'h00;
  logic [3:0][7:0] m = '0;
  pmuisa_pwr_t     pwr = PMUISA_ACTIVE;
  int              mismatches = 0, n_checks = 0, cyc = 0;

  pmuisa_top #(.HOLD_UNIT_CYC(8)) u_dut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_power_down_pin(pdn),
    .i_remote_wake_pin(rwk), .i_power_button_pin(btn),
    .i_reset_in_pin(s2[3]), .i_vbus_pin(vbus), .i_gpio_pin(gpio),
    .i_supply_voltage_monitor(s1[1]), .i_die_overtemperature(s1[0]),
    .i_regulator_fault(s2[4]), .i_watchdog_expiry(s2[2]),
    .i_rtc_tick(s2[1]), .i_rtc_alarm(s2[0]),
    .i_adc_manual_conversion_done(adc[2]),
    .i_adc_periodic_compare_one(adc[1]),
    .i_adc_periodic_compare_zero(adc[0]), .i_power_state(pwr),
    .i_iface_spi(spi), .i_rtc_tick_en(ten), .i_hold_delay_setting(hld),
    .i_gpio_rise_en(re), .i_gpio_fall_en(fe), .i_mask_group_one(m[0]),
    .i_mask_group_two(m[1]), .i_mask_group_three(m[2]),
    .i_mask_group_four(m[3]), .i_clear_on_write(cow), .i_pending_en(pen),
    .i_int_active_high(ah), .i_int_mask_in_sleep(ms),
    .i_acc_valid(hv), .i_acc_port(hp), .i_acc_write(hw),
    .i_acc_group(hg), .i_acc_wdata(hwd), .o_acc_ack(ack), .o_acc_err(err),
    .o_acc_rdata(rdat), .o_int(irq), .o_wake_req(wake)
  );
  pmuisa_host_model u_host (
    .i_mclk(clk), .i_ack(ack), .i_err(err), .i_rdata(rdat),
    .o_valid(hv), .o_port(hp), .o_write(hw), .o_group(hg), .o_wdata(hwd)
  );

  initial forever #10 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) n_wake <= n_wake + 8'h01;
    // the whole sequence needs well under 2000 cycles
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic chk(input logic [7:0] x, input logic [7:0] got);
    n_checks++;
    if (got !== x) begin
      $display("ERROR %0t expected %h got %h", $time, x, got);
      mismatches++;
    end
  endtask : chk
  task automatic rd(input logic [2:0] gr, input logic [7:0] x);
    u_host.acc(PMUISA_PORT_CFG, 1'b0, gr, 8'h00, r, e);
    chk(x, r);
  endtask : rd
  task automatic wr(input logic [2:0] gr, input logic [7:0] dat);
    u_host.acc(PMUISA_PORT_CFG, 1'b1, gr, dat, r, e);
  endtask : wr
  task automatic wk(input logic [7:0] x);
    chk(x, n_wake - w0);
    w0 = n_wake;
  endtask : wk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    wt(16);
    rst_n <= 1'b1;
    wt(4);
    w0 = n_wake;
    s1 <= 2'h3;
    pdn <= 1'b1;
    wt(8);
    rwk <= 1'b0;
    wt(8);
    btn <= 1'b0;
    wt(20);
    rd(0, 8'h7E);
    wk(8'h02);
    rwk <= 1'b1;
    btn <= 1'b1;
    wt(8);
    rd(0, 8'h00);
    pwr <= PMUISA_OFF;
    s1 <= 2'h2;
    rwk <= 1'b0;
    wt(8);
    rd(0, 8'h00);
    wk(8'h01);
    rwk <= 1'b1;
    pwr <= PMUISA_SLEEP;
    for (int i = 4; i >= 0; i--) begin
      s2[i] <= 1'b1;
      wt(8);
    end
    rd(1, 8'h57);
    wk(8'h03);
    ten <= 1'b0;
    s2 <= 5'h00;
    wt(8);
    s2 <= 5'h02;
    wt(8);
    rd(1, 8'h00);
    pwr <= PMUISA_ACTIVE;
    m <= '1;
    s2 <= 5'h1D;
    wt(8);
    chk(8'h01, {7'h00, irq});
    rd(1, 8'h00);
    wk(8'h00);
    m <= '0;
    vbus <= 1'b1;
    wt(8);
    for (int i = 0; i < 3; i++) begin
      adc[i] <= 1'b1;
      wt(1);
      adc <= 3'h0;
      wt(8);
    end
    rd(2, 8'h87);
    wk(8'h04);
    re <= 8'h0F;
    fe <= 8'hF0;
    wt(2);
    gpio <= 8'hFF;
    wt(8);
    rd(3, 8'h0F);
    gpio <= 8'h00;
    wt(8);
    rd(3, 8'hF0);
    rd(3, 8'h00);
    wk(8'h02);
    gpio <= 8'hFF;
    wt(8);
    chk(8'h00, {7'h00, irq});
    ah <= 1'b1;
    wt(2);
    chk(8'h01, {7'h00, irq});
    ah <= 1'b0;
    cow <= 1'b1;
    wr(3, 8'h05);
    rd(3, 8'h0A);
    rd(3, 8'h0A);
    wr(3, 8'hFF);
    rd(3, 8'h00);
    cow <= 1'b0;
    u_host.acc(PMUISA_PORT_VSCALE, 1'b0, 3'h1, 8'h00, r, e);
    chk(8'hFF, r);
    chk(8'h01, {7'h00, e});
    spi <= 1'b1;
    rd(0, 8'h00);
    chk(8'h00, {7'h00, e});
    u_host.acc(PMUISA_PORT_VSCALE, 1'b1, 3'h3, 8'hFF, r, e);
    chk(8'h01, {7'h00, e});
    spi <= 1'b0;
    pen <= 1'b1;
    s2 <= 5'h00;
    wt(8);
    s2 <= 5'h04;
    wt(8);
    s2 <= 5'h00;
    wt(2);
    s2 <= 5'h04;
    wt(8);
    rd(0, 8'h00);
    rd(1, 8'h04);
    rd(1, 8'h04);
    rd(1, 8'h00);
    hld <= 2'h1;
    btn <= 1'b0;
    wt(14);
    rd(0, 8'h02);
    wt(8);
    rd(0, 8'h04);
    btn <= 1'b1;
    s2 <= 5'h00;
    ms <= 1'b1;
    pwr <= PMUISA_SLEEP;
    wt(4);
    rd(4, 8'h5A);
    rd(7, 8'hFF);
    s2 <= 5'h04;
    wt(6);
    chk(8'h01, {7'h00, irq});
    ms <= 1'b0;
    wt(3);
    chk(8'h00, {7'h00, irq});
    m <= '1;
    wt(3);
    chk(8'h01, {7'h00, irq});
    rd(1, 8'h04);
    m <= '0;
    finish_test();
  end
endmodule : tb_pmu_interrupt_source_aggregator
